// file: rtl/sync_frequency_meter.sv
// Purpose: measures vertical frame period and horizontal line rate of incoming sync
// Assumes: sync pulses are active high; pins are asynchronous to sys_clk
// Notes: results are read-only; read the high byte before the low byte
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module sync_frequency_meter #(
  parameter int HWINDOW_CYC = sync_meter_pkg::HWINDOW_CYC,
  parameter int HPERIOD_CYC = sync_meter_pkg::HPERIOD_CYC,
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  localparam int PER_W = $clog2(HPERIOD_CYC + 1);
  localparam int TICK_W = $clog2(sync_meter_pkg::TICK_CYC);
  localparam int VC_W = sync_meter_pkg::VCOUNT_W;
  localparam int HC_W = sync_meter_pkg::HCOUNT_W;
  localparam int VL_W = sync_meter_pkg::VLOW_W;
  localparam int HL_W = sync_meter_pkg::HLOW_W;
  localparam int NEV = sync_meter_pkg::EV_COUNT;

  // sync input conditioning
  logic hs_meta_reg, hs_sync_reg, hs_prev_reg;
  logic vs_meta_reg, vs_sync_reg, vs_prev_reg;
  logic h_edge, v_edge;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hs_meta_reg <= 1'b0;
      hs_sync_reg <= 1'b0;
      hs_prev_reg <= 1'b0;
      vs_meta_reg <= 1'b0;
      vs_sync_reg <= 1'b0;
      vs_prev_reg <= 1'b0;
    end else begin
      hs_meta_reg <= hsync;
      hs_sync_reg <= hs_meta_reg;
      hs_prev_reg <= hs_sync_reg;
      vs_meta_reg <= vsync;
      vs_sync_reg <= vs_meta_reg;
      vs_prev_reg <= vs_sync_reg;
    end
  end

  // leading edge marks one pulse; width of the pulse does not matter
  assign h_edge = hs_sync_reg & ~hs_prev_reg;
  assign v_edge = vs_sync_reg & ~vs_prev_reg;

  // register read side effect
  logic ar_take;
  logic [5:0] ar_idx;
  logic rd_vhigh, rd_hhigh;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign ar_idx = s_axi_araddr[7:2];
  assign rd_vhigh = ar_take && ar_idx == sync_meter_pkg::VFRAME_HIGH_IDX;
  assign rd_hhigh = ar_take && ar_idx == sync_meter_pkg::HLINE_HIGH_IDX;

  // vertical period measurement
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;
  logic [VC_W-1:0] vframe_period_count_reg;
  logic vcount_ovf_reg;
  logic v_ovf_now;
  logic vertical_overflow_flag_reg;
  logic [VC_W-VL_W-1:0] vframe_high_bits_reg;
  logic [VL_W-1:0] vframe_buf_reg;
  logic [VL_W-1:0] vframe_period_low_reg;

  // one tick every sixteen clocks, realigned at each frame start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= '0;
    end else if (v_edge) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  assign tick = &tick_cnt_reg;

  // 8192 ticks of 16 cycles is the overflow point, one tick past range
  assign v_ovf_now = tick && !vcount_ovf_reg && (&vframe_period_count_reg);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vframe_period_count_reg <= '0;
      vcount_ovf_reg <= 1'b0;
    end else if (v_edge) begin
      vframe_period_count_reg <= '0;
      vcount_ovf_reg <= 1'b0;
    end else if (v_ovf_now) begin
      vcount_ovf_reg <= 1'b1;
    end else if (tick && !vcount_ovf_reg) begin
      vframe_period_count_reg <= vframe_period_count_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vframe_high_bits_reg <= '0;
      vframe_buf_reg <= '0;
    end else if (v_edge) begin
      vframe_high_bits_reg <= vframe_period_count_reg[VC_W-1:VL_W];
      vframe_buf_reg <= vframe_period_count_reg[VL_W-1:0];
    end
  end

  // flag follows each finished frame, but rises at once on overflow
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vertical_overflow_flag_reg <= 1'b0;
    end else if (v_edge) begin
      vertical_overflow_flag_reg <= vcount_ovf_reg | v_ovf_now;
    end else if (v_ovf_now) begin
      vertical_overflow_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vframe_period_low_reg <= sync_meter_pkg::MEAS_RESET;
    end else if (rd_vhigh) begin
      vframe_period_low_reg <= vframe_buf_reg;
    end
  end

  // horizontal line counting
  logic [PER_W-1:0] period_cnt_reg;
  logic in_window, window_end;
  logic [HC_W-1:0] hline_cnt_reg;
  logic hline_ovf_reg;
  logic h_ovf_now;
  logic horizontal_overflow_flag_reg;
  logic [HC_W-HL_W-1:0] hline_high_bits_reg;
  logic [HL_W-1:0] hline_buf_reg;
  logic [HL_W-1:0] hline_count_low_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      period_cnt_reg <= '0;
    end else if (period_cnt_reg == PER_W'(HPERIOD_CYC - 1)) begin
      period_cnt_reg <= '0;
    end else begin
      period_cnt_reg <= period_cnt_reg + 1'b1;
    end
  end

  assign in_window = period_cnt_reg < PER_W'(HWINDOW_CYC);
  assign window_end = period_cnt_reg == PER_W'(HWINDOW_CYC);
  // the 4096th pulse of a window is the first one past range
  assign h_ovf_now = h_edge && in_window && (&hline_cnt_reg) && !hline_ovf_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hline_cnt_reg <= '0;
      hline_ovf_reg <= 1'b0;
    end else if (window_end) begin
      hline_cnt_reg <= '0;
      hline_ovf_reg <= 1'b0;
    end else if (h_ovf_now) begin
      hline_ovf_reg <= 1'b1;
    end else if (h_edge && in_window && !hline_ovf_reg) begin
      hline_cnt_reg <= hline_cnt_reg + 1'b1;
    end
  end

  // with a 32 ms window, count/32 is lines per ms, i.e. kHz
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hline_high_bits_reg <= '0;
      hline_buf_reg <= '0;
    end else if (window_end) begin
      hline_high_bits_reg <= hline_cnt_reg[HC_W-1:HL_W];
      hline_buf_reg <= hline_cnt_reg[HL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      horizontal_overflow_flag_reg <= 1'b0;
    end else if (h_ovf_now) begin
      horizontal_overflow_flag_reg <= 1'b1;
    end else if (window_end) begin
      horizontal_overflow_flag_reg <= hline_ovf_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hline_count_low_reg <= '0;
    end else if (rd_hhigh) begin
      hline_count_low_reg <= hline_buf_reg;
    end
  end

  // register view
  logic [7:0] vframe_period_high, vframe_period_low;
  logic [7:0] hline_count_high, hline_count_low;

  assign vframe_period_high = {vertical_overflow_flag_reg, 2'b00, vframe_high_bits_reg};
  assign vframe_period_low = vframe_period_low_reg;
  assign hline_count_high = {horizontal_overflow_flag_reg, hline_high_bits_reg};
  assign hline_count_low = {3'b000, hline_count_low_reg};

  // interrupts
  logic [NEV-1:0] int_status_reg, int_mask_reg;
  logic [NEV-1:0] ev_set, int_clear;
  logic wr_fire;
  logic [5:0] wr_idx;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_full_reg, w_full_reg;

  assign ev_set = {h_ovf_now, v_ovf_now, window_end, v_edge};
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_idx = awaddr_reg[7:2];
  assign int_clear = (wr_fire && wr_idx == sync_meter_pkg::INT_STATUS_IDX && wstrb_reg[0])
                     ? wdata_reg[NEV-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_status_reg <= sync_meter_pkg::INT_RESET;
    end else begin
      int_status_reg <= (int_status_reg & ~int_clear) | ev_set;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_mask_reg <= sync_meter_pkg::INT_RESET;
    end else if (wr_fire && wr_idx == sync_meter_pkg::INT_MASK_IDX && wstrb_reg[0]) begin
      int_mask_reg <= wdata_reg[NEV-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((int_status_reg & ~int_clear | ev_set) & int_mask_reg);
    end
  end

  // AXI4-Lite write channel
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      w_full_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  // measurement registers accept writes with no effect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sync_meter_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      case (wr_idx)
        sync_meter_pkg::VFRAME_HIGH_IDX, sync_meter_pkg::VFRAME_LOW_IDX,
        sync_meter_pkg::HLINE_HIGH_IDX, sync_meter_pkg::HLINE_LOW_IDX,
        sync_meter_pkg::INT_STATUS_IDX, sync_meter_pkg::INT_MASK_IDX: begin
          s_axi_bresp <= sync_meter_pkg::RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= sync_meter_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sync_meter_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sync_meter_pkg::RESP_OKAY;
      case (ar_idx)
        sync_meter_pkg::VFRAME_HIGH_IDX: s_axi_rdata <= {24'h000000, vframe_period_high};
        // low read returns the value present before any same-cycle copy
        sync_meter_pkg::VFRAME_LOW_IDX: s_axi_rdata <= {24'h000000, vframe_period_low};
        sync_meter_pkg::HLINE_HIGH_IDX: s_axi_rdata <= {24'h000000, hline_count_high};
        sync_meter_pkg::HLINE_LOW_IDX: s_axi_rdata <= {24'h000000, hline_count_low};
        sync_meter_pkg::INT_STATUS_IDX: s_axi_rdata <= {28'h0000000, int_status_reg};
        sync_meter_pkg::INT_MASK_IDX: s_axi_rdata <= {28'h0000000, int_mask_reg};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= sync_meter_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: rtl/sync_meter_pkg.sv
// Purpose: constants shared by the sync frequency meter
// Assumes: 20 MHz system clock, AXI4-Lite register access
// Notes: register offsets are word indices; byte address is four times the index
package sync_meter_pkg;

  // register word indices
  localparam logic [5:0] VFRAME_HIGH_IDX = 6'h0d;
  localparam logic [5:0] VFRAME_LOW_IDX = 6'h0e;
  localparam logic [5:0] HLINE_HIGH_IDX = 6'h0f;
  localparam logic [5:0] HLINE_LOW_IDX = 6'h10;
  localparam logic [5:0] INT_STATUS_IDX = 6'h20;
  localparam logic [5:0] INT_MASK_IDX = 6'h21;

  // reset values
  localparam logic [7:0] MEAS_RESET = 8'h00;
  localparam logic [3:0] INT_RESET = 4'h0;

  // field positions
  localparam int OVF_BIT = 7;
  localparam int VCOUNT_W = 13;
  localparam int VLOW_W = 8;
  localparam int HCOUNT_W = 12;
  localparam int HLOW_W = 5;

  // interrupt status bit positions
  localparam int EV_VFRAME = 0;
  localparam int EV_HWINDOW = 1;
  localparam int EV_VOVF = 2;
  localparam int EV_HOVF = 3;
  localparam int EV_COUNT = 4;

  // timing
  localparam int TICK_CYC = 16;
  localparam int CLK_PERIOD_NS = 50;
  localparam int HWINDOW_NS = 32000000;
  localparam int HPERIOD_NS = 32768000;
  localparam int HWINDOW_CYC = HWINDOW_NS / CLK_PERIOD_NS;
  localparam int HPERIOD_CYC = HPERIOD_NS / CLK_PERIOD_NS;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: bench/sync_meter_assertions.sv
// Purpose: port-level checks on the register bus and readout shapes
// Assumes: one clock domain, rst asynchronous and active high
// Notes: measured values themselves are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module sync_meter_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic take;
  logic [5:0] idx;
  assign take = s_axi_arvalid && s_axi_arready;
  assign idx = s_axi_araddr[7:2];
  a_reset_quiet: assert property ($fell(rst) |-> !s_axi_rvalid && !s_axi_bvalid && !irq)
    else $error("outputs busy after reset");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_r_follows: assert property (take |=> s_axi_rvalid)
    else $error("read answer late");
  a_meas_okay: assert property (take && idx inside {[6'h0d:6'h10]} |=> s_axi_rresp == 2'b00)
    else $error("measurement read refused");
  a_unmapped_err: assert property (take && !(idx inside {[6'h0d:6'h10], 6'h20, 6'h21})
    |=> s_axi_rresp == sync_meter_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_vhigh_shape: assert property (take && idx == 6'h0d |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:5] == 2'h0)
    else $error("vertical high has stray bits");
  a_vlow_shape: assert property (take && idx == 6'h0e |=> s_axi_rdata[31:8] == 24'h0)
    else $error("vertical low has stray bits");
  a_hlow_shape: assert property (take && idx == 6'h10 |=> s_axi_rdata[31:5] == 27'h0)
    else $error("horizontal low upper bits set");
  c_vhigh: cover property (take && idx == 6'h0d);
  c_hhigh: cover property (take && idx == 6'h0f);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// file: bench/sync_source.sv
// Purpose: video source model driving both sync pins
// Assumes: gap values are cycles between leading edges, zero stops the pin
// Notes: stopped pins rest low, the inactive sync level
`timescale 1ns/10ps
`default_nettype none
module sync_source (
  input wire logic sys_clk,
  input wire logic [15:0] h_gap,
  input wire logic [15:0] v_gap,
  output logic hsync,
  output logic vsync
);
  logic [15:0] h_cnt = 16'h0;
  logic [15:0] v_cnt = 16'h0;
  initial hsync = 1'b0;
  initial vsync = 1'b0;
  always @(posedge sys_clk) begin
    h_cnt <= (h_cnt + 16'h1 >= h_gap) ? 16'h0 : h_cnt + 16'h1;
    hsync <= (h_gap != 16'h0) && (h_cnt < (h_gap >> 1));
  end
  // short vsync pulse so the leading edge is the only frame marker
  always @(posedge sys_clk) begin
    v_cnt <= (v_cnt + 16'h1 >= v_gap) ? 16'h0 : v_cnt + 16'h1;
    vsync <= (v_gap != 16'h0) && (v_cnt < 16'h8);
  end
endmodule
`default_nettype wire

// file: bench/sync_frequency_meter_tb.sv
// Purpose: self-checking bench for the sync frequency meter
// Assumes: shortened horizontal window, AXI4-Lite master tasks
// Notes: counts are judged within one tick of the ideal value
`timescale 1ns/10ps
`default_nettype none
module sync_frequency_meter_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsync, vsync, aw_r, w_r, b_v, ar_r, r_v, irq;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_rd = 1'b0;
  logic [7:0] aw_a = 8'h0, ar_a = 8'h0;
  logic [31:0] w_d = 32'h0, r_d, d, e;
  logic [1:0] b_resp, r_resp, rsp;
  logic [15:0] h_gap = 16'h0, v_gap = 16'h0;
  int err_total = 0;
  int total_checks = 0;
  sync_source u_sync_source (.sys_clk(sys_clk), .h_gap(h_gap), .v_gap(v_gap),
    .hsync(hsync), .vsync(vsync));
  sync_frequency_meter #(.HWINDOW_CYC(8400), .HPERIOD_CYC(8600)) u_sync_frequency_meter (
    .sys_clk(sys_clk), .rst(rst), .hsync(hsync), .vsync(vsync),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_rd),
    .irq(irq));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one tick of slack: edges are not aligned to the tick or window start
  task automatic near(input logic [12:0] got, input int exp);
    total_checks++;
    if (got !== 13'(exp) && got !== 13'(exp - 1) && got !== 13'(exp + 1)) begin
      err_total++;
      $display("ERROR %0t: count %0d not near %0d", $time, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n > 30000) begin
      err_total++;
      $display("ERROR %0t: wait ran out", $time);
      wrap_up();
    end
  endtask
  // ready is sampled mid-cycle: it is what the next rising edge sees
  task automatic wr(input logic [5:0] idx, input logic [31:0] v);
    int n;
    logic ta, tw, tb;
    aw_a <= {idx, 2'b00};
    w_d <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    tb = 1'b0;
    n = 0;
    while (!tb) begin
      @(negedge sys_clk);
      ta = aw_v && aw_r;
      tw = w_v && w_r;
      tb = b_v && b_r;
      rsp = b_resp;
      @(posedge sys_clk);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
      if (tb) b_r <= 1'b0;
      hang(n++ * 200);
    end
    chk(32'(rsp), 32'(sync_meter_pkg::RESP_OKAY));
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [5:0] idx);
    int n;
    logic ta, tr;
    ar_a <= {idx, 2'b00};
    ar_v <= 1'b1;
    r_rd <= 1'b1;
    tr = 1'b0;
    n = 0;
    while (!tr) begin
      @(negedge sys_clk);
      ta = ar_v && ar_r;
      tr = r_v && r_rd;
      d = r_d;
      rsp = r_resp;
      @(posedge sys_clk);
      if (ta) ar_v <= 1'b0;
      if (tr) r_rd <= 1'b0;
      hang(n++ * 200);
    end
    @(posedge sys_clk);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      hang(n++);
    end while (irq !== 1'b1);
    @(posedge sys_clk);
  endtask
  task automatic irq_low();
    @(negedge sys_clk);
    chk(32'(irq), 32'h0);
    @(posedge sys_clk);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rd(6'(sync_meter_pkg::VFRAME_HIGH_IDX + i));
      chk(d, 32'h0);
    end
    wr(sync_meter_pkg::HLINE_HIGH_IDX, 32'hff);
    rd(sync_meter_pkg::HLINE_HIGH_IDX);
    chk(d, 32'h0);
    rd(6'h3f);
    chk(32'(rsp), 32'(sync_meter_pkg::RESP_SLVERR));
    rd(sync_meter_pkg::INT_MASK_IDX);
    chk(d, 32'h0);
  endtask
  task automatic t_vertical();
    v_gap <= 16'h12c0;
    wr(sync_meter_pkg::INT_MASK_IDX, 32'h1);
    wr(sync_meter_pkg::INT_STATUS_IDX, 32'hf);
    wait_irq();
    wr(sync_meter_pkg::INT_STATUS_IDX, 32'h1);
    irq_low();
    wait_irq();
    rd(sync_meter_pkg::VFRAME_HIGH_IDX);
    e = d;
    rd(sync_meter_pkg::VFRAME_LOW_IDX);
    chk(32'(e[7:5]), 32'h0);
    near({e[4:0], d[7:0]}, 300);
    v_gap <= 16'h0;
  endtask
  task automatic t_horizontal(input logic [15:0] gap, input logic ovf, input int lines);
    h_gap <= gap;
    wr(sync_meter_pkg::INT_MASK_IDX, 32'h2);
    wr(sync_meter_pkg::INT_STATUS_IDX, 32'hf);
    wait_irq();
    wr(sync_meter_pkg::INT_STATUS_IDX, 32'hf);
    wait_irq();
    rd(sync_meter_pkg::HLINE_HIGH_IDX);
    e = d;
    rd(sync_meter_pkg::HLINE_LOW_IDX);
    chk(32'(e[7]), 32'(ovf));
    if (!ovf) near({1'b0, e[6:0], d[4:0]}, lines);
  endtask
  task automatic t_mask();
    rd(sync_meter_pkg::INT_STATUS_IDX);
    chk(32'(d[3]), 32'h1);
    wr(sync_meter_pkg::INT_MASK_IDX, 32'h0);
    irq_low();
    h_gap <= 16'h0;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_vertical();
    t_horizontal(16'ha, 1'b0, 840);
    t_horizontal(16'h2, 1'b1, 0);
    t_mask();
    t_horizontal(16'h0, 1'b0, 0);
    wrap_up();
  end
endmodule
bind sync_frequency_meter sync_meter_assertions #(.ADDR_W(ADDR_W)) u_sync_meter_assertions (
  .sys_clk(sys_clk), .rst(rst), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .irq(irq));
`default_nettype wire
